//--- verilog/stfd_decoder.sv
// Servo tribit format decoder with AXI4-Lite status and control
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`include "stfd_defines.svh"
module stfd_decoder (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        syncDetect,
  output logic             presetGate,
  output logic             peakAGate,
  output logic             peakBGate,
  output logic             transferGate,
  output logic             decClk,
  output logic             servoByteClk,
  output logic             formatPulse,
  output logic             indexPulse,
  output logic             outerGuardPulse,
  output logic             innerGuardPulse,
  output logic             demodOk,
  output logic             slopeSel,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import stfd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] phase_reg;
  logic [7:0] period_reg;
  logic [7:0] acc4_reg;
  logic [7:0] acc24_reg;
  logic       dataBit_reg;
  logic [4:0] fmtShift_reg;
  logic       compare_reg;
  logic       alt_reg;
  logic       slope_reg;
  logic       ok_reg;
  logic       syncAccept;
  logic       syncWindow;
  logic       lost;
  logic [8:0] acc4_next;
  logic [8:0] acc24_next;
  logic [7:0] quarter;
  stfd_ivl_t  ivl;
  logic       aEarly;

  // Outside the window a detect pulse is a servo data bit
  assign syncWindow = !ok_reg ||
                      (phase_reg >= period_reg - (period_reg >> 3));
  assign syncAccept = syncDetect && syncWindow;
  assign lost       = (phase_reg == `STFD_LOST_PERIOD);

  ////////////////////////////////////////////////////////////////////////
  // Digital lock: phase restarts on each accepted sync bit
  always_ff @(posedge clk_sys) begin
    if (srst || syncAccept || lost) begin
      phase_reg <= 8'h00;
    end else begin
      phase_reg <= phase_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      period_reg <= 8'(`STFD_NOM_PERIOD);
      ok_reg     <= 1'b0;
    end else if (lost) begin
      ok_reg <= 1'b0;
    end else if (syncAccept) begin
      // Out of range periods are not loaded and clear ok_reg so one stray pulse cannot pull
      if (phase_reg + 8'h01 >= `STFD_MIN_PERIOD &&
          phase_reg + 8'h01 <= `STFD_MAX_PERIOD) begin
        period_reg <= phase_reg + 8'h01;
        ok_reg     <= 1'b1;
      end else begin
        ok_reg <= 1'b0;
      end
    end
  end
  assign demodOk = ok_reg;

  ////////////////////////////////////////////////////////////////////////
  // Fractional dividers from one phase keep the six to one ratio exact
  assign acc4_next  = {1'b0, acc4_reg} + 9'(`STFD_DEC_PER_BYTE);
  assign acc24_next = {1'b0, acc24_reg} +
                      9'(`STFD_DEC_PER_BYTE * `STFD_BCLK_PER_DEC);

  always_ff @(posedge clk_sys) begin
    if (srst || syncAccept) begin
      acc4_reg <= 8'h00;
      decClk   <= syncAccept && !srst;
    end else if (acc4_next >= {1'b0, period_reg}) begin
      acc4_reg <= 8'(acc4_next - {1'b0, period_reg});
      decClk   <= 1'b1;
    end else begin
      acc4_reg <= acc4_next[7:0];
      decClk   <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || syncAccept) begin
      acc24_reg    <= 8'h00;
      servoByteClk <= syncAccept && !srst;
    end else if (acc24_next >= {1'b0, period_reg}) begin
      acc24_reg    <= 8'(acc24_next - {1'b0, period_reg});
      servoByteClk <= 1'b1;
    end else begin
      acc24_reg    <= acc24_next[7:0];
      servoByteClk <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sampling gates
  assign quarter = period_reg >> 2;
  always_comb begin
    if (phase_reg < quarter) begin
      ivl = IVL_PRESET;
    end else if (phase_reg < (quarter << 1)) begin
      ivl = IVL_EARLY;
    end else if (phase_reg < quarter + (quarter << 1)) begin
      ivl = IVL_LATE;
    end else begin
      ivl = IVL_TRANSFER;
    end
  end

  assign aEarly = alt_reg ^ slope_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      presetGate   <= 1'b0;
      peakAGate    <= 1'b0;
      peakBGate    <= 1'b0;
      transferGate <= 1'b0;
    end else begin
      presetGate   <= 1'b0;
      peakAGate    <= 1'b0;
      peakBGate    <= 1'b0;
      transferGate <= 1'b0;
      case (ivl)
        IVL_PRESET: begin
          presetGate <= 1'b1;
        end
        IVL_EARLY: begin
          peakAGate <= aEarly;
          peakBGate <= !aEarly;
        end
        IVL_LATE: begin
          peakAGate <= !aEarly;
          peakBGate <= aEarly;
        end
        IVL_TRANSFER: begin
          transferGate <= 1'b1;
        end
        default: begin
          presetGate <= 1'b0;
        end
      endcase
    end
  end

  // Alignment overrides the per byte toggle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      alt_reg <= `STFD_ALT_ALIGN;
    end else if (formatPulse) begin
      alt_reg <= `STFD_ALT_ALIGN;
    end else if (syncAccept) begin
      alt_reg <= !alt_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Format indicator capture
  always_ff @(posedge clk_sys) begin
    if (srst || syncAccept) begin
      dataBit_reg <= 1'b0;
    end else if (syncDetect) begin
      dataBit_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fmtShift_reg <= 5'h00;
      compare_reg  <= 1'b0;
    end else begin
      compare_reg <= syncAccept;
      if (syncAccept) begin
        fmtShift_reg <= {fmtShift_reg[3:0], dataBit_reg};
      end
    end
  end

  // Segments of 79 normal bytes are all zero, so they never match
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      formatPulse     <= 1'b0;
      indexPulse      <= 1'b0;
      outerGuardPulse <= 1'b0;
      innerGuardPulse <= 1'b0;
    end else begin
      formatPulse     <= compare_reg &&
                         (fmtShift_reg == `STFD_PAT_INDEX ||
                          fmtShift_reg == `STFD_PAT_OUTER ||
                          fmtShift_reg == `STFD_PAT_INNER ||
                          fmtShift_reg == `STFD_PAT_DATA);
      indexPulse      <= compare_reg &&
                         fmtShift_reg == `STFD_PAT_INDEX;
      outerGuardPulse <= compare_reg &&
                         fmtShift_reg == `STFD_PAT_OUTER;
      innerGuardPulse <= compare_reg &&
                         fmtShift_reg == `STFD_PAT_INNER;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic       awHeld_reg;
  logic       wHeld_reg;
  logic [3:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic       doWrite;

  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHeld_reg && wHeld_reg;
  assign slopeSel = slope_reg;

  always_ff @(posedge clk_sys) begin
    if (srst || doWrite) begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (s_axi_awvalid && s_axi_awready) begin
      awAddr_reg <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      slope_reg    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `STFD_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      if (awAddr_reg == `STFD_ADDR_CTRL) begin
        s_axi_bresp <= `STFD_RESP_OKAY;
        if (wStrb_reg[0]) begin
          slope_reg <= wData_reg[0];
        end
      end else begin
        s_axi_bresp <= (awAddr_reg == `STFD_ADDR_STATUS ||
                        awAddr_reg == `STFD_ADDR_PERIOD ||
                        awAddr_reg == `STFD_ADDR_LAYOUT) ?
                       `STFD_RESP_OKAY : `STFD_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `STFD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `STFD_RESP_OKAY;
      case (s_axi_araddr)
        `STFD_ADDR_CTRL:   s_axi_rdata <= {31'h0, slope_reg};
        `STFD_ADDR_STATUS: s_axi_rdata <= {26'h0, fmtShift_reg, ok_reg};
        `STFD_ADDR_PERIOD: s_axi_rdata <= {24'h0, period_reg};
        `STFD_ADDR_LAYOUT: begin
          s_axi_rdata <= {2'h0, `STFD_INNER_TRACKS,
                          `STFD_OUTER_TRACKS, `STFD_ZONE_TRACKS};
        end
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `STFD_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_index;
    @(posedge clk_sys) disable iff (srst)
      compare_reg && fmtShift_reg == `STFD_PAT_INDEX
        |=> indexPulse && formatPulse;
  endproperty
  a_index: assert property (p_index) else $error("index missed");

  property p_data;
    @(posedge clk_sys) disable iff (srst)
      compare_reg && fmtShift_reg == `STFD_PAT_DATA
        |=> formatPulse && !indexPulse && !outerGuardPulse
            && !innerGuardPulse;
  endproperty
  a_data: assert property (p_data) else $error("data zone bad");

  property p_guard;
    @(posedge clk_sys) disable iff (srst)
      outerGuardPulse || innerGuardPulse
        |-> $past(fmtShift_reg) == `STFD_PAT_OUTER ||
            $past(fmtShift_reg) == `STFD_PAT_INNER;
  endproperty
  a_guard: assert property (p_guard) else $error("guard bad");

  property p_once;
    @(posedge clk_sys) disable iff (srst)
      formatPulse |-> $past(syncAccept, 2);
  endproperty
  a_once: assert property (p_once) else $error("compare off byte");

  property p_gates;
    @(posedge clk_sys) disable iff (srst)
      $onehot0({presetGate, transferGate, peakAGate})
      && (peakAGate != peakBGate || !(peakAGate || peakBGate));
  endproperty
  a_gates: assert property (p_gates) else $error("gate overlap");

  property p_preset;
    @(posedge clk_sys) disable iff (srst)
      syncAccept |=> ##1 presetGate;
  endproperty
  a_preset: assert property (p_preset) else $error("no preset");

  property p_align;
    @(posedge clk_sys) disable iff (srst)
      formatPulse |=> alt_reg == `STFD_ALT_ALIGN;
  endproperty
  a_align: assert property (p_align) else $error("no align");

  property p_suppress;
    @(posedge clk_sys) disable iff (srst)
      syncDetect && !syncWindow |=> dataBit_reg && phase_reg != 8'h00;
  endproperty
  a_suppress: assert property (p_suppress) else $error("data bit");

  property p_lost;
    @(posedge clk_sys) disable iff (srst)
      lost |=> !demodOk;
  endproperty
  a_lost: assert property (p_lost) else $error("ok kept");
endmodule // stfd_decoder

//--- verilog/stfd_defines.svh
// Constants for the servo tribit format decoder
`ifndef STFD_DEFINES_SVH
`define STFD_DEFINES_SVH
`define STFD_SYS_HZ       50000000
`define STFD_DEC_HZ       1612000
`define STFD_DEC_PER_BYTE 4
`define STFD_BCLK_PER_DEC 6
`define STFD_NOM_PERIOD   ((`STFD_SYS_HZ * `STFD_DEC_PER_BYTE) / `STFD_DEC_HZ)
`define STFD_MIN_PERIOD   8'd100
`define STFD_MAX_PERIOD   8'd150
`define STFD_LOST_PERIOD  8'hFF
`define STFD_PAT_INDEX    5'h1B
`define STFD_PAT_OUTER    5'h17
`define STFD_PAT_DATA     5'h15
`define STFD_PAT_INNER    5'h1D
`define STFD_ALT_ALIGN    1'b0
`define STFD_ZONE_TRACKS  10'd823
`define STFD_OUTER_TRACKS 10'd22
`define STFD_INNER_TRACKS 10'd80
`define STFD_ADDR_CTRL    4'h0
`define STFD_ADDR_STATUS  4'h4
`define STFD_ADDR_PERIOD  4'h8
`define STFD_ADDR_LAYOUT  4'hC
`define STFD_RESP_OKAY    2'h0
`define STFD_RESP_SLVERR  2'h2
`endif

//--- verilog/stfd_pkg.sv
// Types for the servo tribit format decoder
package stfd_pkg;
  typedef enum logic [1:0] {
    IVL_PRESET   = 2'b00,
    IVL_EARLY    = 2'b01,
    IVL_LATE     = 2'b10,
    IVL_TRANSFER = 2'b11
  } stfd_ivl_t;
endpackage

//--- bench/stfd_servo_src.sv
// Servo read channel model: sync and servo data bit detect pulses
module stfd_servo_src #(
  parameter int BYTE    = 124,
  parameter int NORMALS = 79
) (
  input  wire logic       clk_sys,
  input  wire logic       start,
  input  wire logic [4:0] code,
  output logic            syncDetect,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ns;
  //////////////////////////////////////////////////////////////////////
  logic [4:0] codeReg;
  logic       dataBit;
  initial begin
    syncDetect = 1'b0;
    busy       = 1'b0;
    codeReg    = 5'h00;
    forever begin
      @(posedge clk_sys);
      if (start) begin
        busy <= 1'b1;
        codeReg = code;
        // Indicator bytes, then the normal bytes of the segment
        for (int b = 0; b < 5 + NORMALS; b++) begin
          for (int c = 0; c < BYTE; c++) begin
            // Data bit sits mid-byte, well clear of the sync window
            dataBit = (b < 5) && codeReg[4 - b] && (c == BYTE / 2);
            syncDetect <= (c == 0) || dataBit;
            @(posedge clk_sys);
          end
        end
        syncDetect <= 1'b0;
        busy       <= 1'b0;
      end
    end
  end
endmodule // stfd_servo_src

//--- bench/test_servo_tribit_format_decoder.sv
// Self-checking bench for the servo tribit format decoder
`include "stfd_defines.svh"
module test_servo_tribit_format_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BYTE = 124;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        start = 1'b0;
  logic [4:0]  code = 5'h00;
  logic        syncDetect, busy, presetGate, peakAGate, peakBGate;
  logic        transferGate, decClk, servoByteClk, formatPulse;
  logic        indexPulse, outerGuardPulse, innerGuardPulse;
  logic        demodOk, slopeSel, awready, wready, bvalid;
  logic        arready, rvalid;
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  evq[$];
  logic [33:0] busq[$];
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          seed = 32'h2e11aa1c;
  logic        slopeExp = 1'b0;
  always #10 clk_sys = ~clk_sys;
  stfd_servo_src #(.BYTE(BYTE), .NORMALS(79)) u_src (
    .clk_sys(clk_sys), .start(start), .code(code),
    .syncDetect(syncDetect), .busy(busy));
  stfd_decoder u_dut (
    .clk_sys(clk_sys), .srst(srst), .syncDetect(syncDetect),
    .presetGate(presetGate), .peakAGate(peakAGate),
    .peakBGate(peakBGate), .transferGate(transferGate),
    .decClk(decClk), .servoByteClk(servoByteClk),
    .formatPulse(formatPulse), .indexPulse(indexPulse),
    .outerGuardPulse(outerGuardPulse), .innerGuardPulse(innerGuardPulse),
    .demodOk(demodOk), .slopeSel(slopeSel),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [35:0] e, input logic [35:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_ev(input logic [3:0] e, input logic [3:0] g);
    chk({32'h0, e}, {32'h0, g});
  endtask
  task automatic cmp_bus(input logic [33:0] e, input logic [33:0] g);
    chk({2'b00, e}, {2'b00, g});
  endtask
  task automatic cmp_gate(input logic [3:0] e, input logic [3:0] g);
    chk({32'h0, e}, {32'h0, g});
  endtask
  task automatic cmp_cnt(input logic [15:0] e, input logic [15:0] g);
    chk({20'h0, e}, {20'h0, g});
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Handshakes are judged at the falling edge, acted on at the rising one
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    logic ac, wc, bc;
    busq.push_back({r, 32'h0});
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    bc = 1'b0;
    while (!bc) begin
      @(negedge clk_sys);
      ac = awvalid && awready;
      wc = wvalid && wready;
      bc = bvalid && bready;
      @(posedge clk_sys);
      if (ac) awvalid <= 1'b0;
      if (wc) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a, input logic [1:0] r,
                     input logic [31:0] d);
    logic ac, rc;
    busq.push_back({r, d});
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    rc = 1'b0;
    while (!rc) begin
      @(negedge clk_sys);
      ac = arvalid && arready;
      rc = rvalid && rready;
      @(posedge clk_sys);
      if (ac) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(negedge clk_sys) begin
    if (bvalid === 1'b1 && bready) cmp_bus(busq.pop_front(), {bresp, 32'h0});
    if (rvalid === 1'b1 && rready) cmp_bus(busq.pop_front(), {rresp, rdata});
  end
  // Processor side watches index and guard band pulses
  always @(negedge clk_sys) begin
    if (!srst && {formatPulse, indexPulse, outerGuardPulse,
                  innerGuardPulse} !== 4'h0) begin
      cmp_ev(evq.size() > 0 ? evq.pop_front() : 4'h0, {formatPulse,
             indexPulse, outerGuardPulse, innerGuardPulse});
    end
  end
  // Two bytes after each indicator: peak gate phase, then transfer gate
  initial begin : gate_watch
    logic s;
    logic f;
    forever begin
      @(negedge clk_sys);
      if (formatPulse === 1'b1) begin
        s = slopeExp;
        for (int k = 0; k < 2; k++) begin
          f = !(s ^ k[0]);
          while ((peakAGate | peakBGate) !== 1'b1) @(negedge clk_sys);
          cmp_gate({~f, f, presetGate, 1'b0}, {peakAGate, peakBGate, 1'b0,
                   transferGate});
          cmp_gate(4'h0, {3'h0, presetGate});
          while ((peakAGate | peakBGate) !== 1'b0) @(negedge clk_sys);
          cmp_gate(4'h1, {3'h0, transferGate});
        end
      end
    end
  end
  // One servo track segment, with register traffic in mid-segment
  task automatic seg(input logic [4:0] c, input logic [3:0] e);
    logic [31:0] d;
    logic [15:0] nd, nb;
    d = $random(seed);
    axw(`STFD_ADDR_CTRL, d, `STFD_RESP_OKAY);
    slopeExp = d[0];
    if (e !== 4'h0) evq.push_back(e);
    code  <= c;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (20 * BYTE) @(posedge clk_sys);
    axr(`STFD_ADDR_CTRL, `STFD_RESP_OKAY, {31'h0, d[0]});
    axr(`STFD_ADDR_STATUS, `STFD_RESP_OKAY, 32'h1);
    axr(`STFD_ADDR_PERIOD, `STFD_RESP_OKAY, BYTE);
    nd = 16'h0;
    nb = 16'h0;
    do @(negedge clk_sys); while (presetGate !== 1'b0);
    do @(negedge clk_sys); while (presetGate !== 1'b1);
    repeat (10 * BYTE) begin
      @(negedge clk_sys);
      nd = nd + decClk;
      nb = nb + servoByteClk;
    end
    cmp_cnt(16'd40, nd);
    cmp_cnt(16'd240, nb);
    do @(negedge clk_sys); while (busy);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    axr(`STFD_ADDR_CTRL, `STFD_RESP_OKAY, 32'h0);
    axr(`STFD_ADDR_STATUS, `STFD_RESP_OKAY, 32'h0);
    axr(`STFD_ADDR_PERIOD, `STFD_RESP_OKAY, `STFD_NOM_PERIOD);
    // Warm-up segment lets the lock settle before any indicator
    seg(5'h00, 4'h0);
    seg(`STFD_PAT_INDEX, 4'b1100);
    seg(`STFD_PAT_OUTER, 4'b1010);
    seg(`STFD_PAT_DATA, 4'b1000);
    seg(`STFD_PAT_INNER, 4'b1001);
    seg(5'h1F, 4'h0);
    axw(`STFD_ADDR_LAYOUT, $random(seed), `STFD_RESP_OKAY);
    axr(`STFD_ADDR_LAYOUT, `STFD_RESP_OKAY, {2'b00, `STFD_INNER_TRACKS,
        `STFD_OUTER_TRACKS, `STFD_ZONE_TRACKS});
    axw(4'h2, $random(seed), `STFD_RESP_SLVERR);
    axr(4'h2, `STFD_RESP_SLVERR, 32'h0);
    repeat (4) @(posedge clk_sys);
    cmp_ev(4'h0, 4'(evq.size()));
    end_of_test();
  end
  // Six segments of about 10500 cycles each, with margin
  initial begin
    #(90000 * 20);
    n_mismatch++;
    end_of_test();
  end
endmodule // test_servo_tribit_format_decoder
